/* src/rx_fmt_consts.svh */
`ifndef RX_FMT_CONSTS_SVH
`define RX_FMT_CONSTS_SVH

// Transaction codes
`define TC_WR_QUAD   4'h0
`define TC_WR_BLK    4'h1
`define TC_WR_RESP   4'h2
`define TC_RD_QUAD   4'h4
`define TC_RD_BLK    4'h5
`define TC_RD_QRESP  4'h6
`define TC_RD_BRESP  4'h7
`define TC_LOCK_REQ  4'h9
`define TC_LOCK_RESP 4'hb

// Acknowledge codes
`define ACK_COMPLETE 4'h1
`define ACK_PENDING  4'h2
`define ACK_BUSY_X   4'h4
`define ACK_BUSY_A   4'h5
`define ACK_BUSY_B   4'h6
`define ACK_DATA_ERR 4'hd
`define ACK_TYPE_ERR 4'he

// Retry phase requested by the receiver when busy
`define PHASE_ANY    2'h0
`define PHASE_A      2'h1
`define PHASE_B      2'h2

// Header quadlet counts
`define HDR_Q_NODATA 3'h3
`define HDR_Q_FULL   3'h4

// Reserved fills of header and status quadlets
`define RESP_PAD     12'h000
`define RESP_Q2      32'h00000000
`define LEN_PAD      16'h0000
`define STAT_PAD_HI  15'h0000
`define STAT_PAD_LO  12'h000

`endif

/* src/rx_fmt_pkg.sv */
package rx_fmt_pkg;

	typedef enum logic [1:0] {
		RT_RETRY1 = 2'h0,
		RT_RETRY_X = 2'h1,
		RT_RETRY_A = 2'h2,
		RT_RETRY_B = 2'h3
	} rt_t;

	// Parsed header of a received packet
	typedef struct packed {
		logic [15:0] dest_id;
		logic [5:0]  tlabel;
		rt_t         rt;
		logic [3:0]  tcode;
		logic [3:0]  pri;
		logic [15:0] src_id;
		logic [15:0] off_hi;
		logic [31:0] off_lo;
		logic [3:0]  rcode;
		logic [31:0] quad_data;
		logic [15:0] data_length;
		logic [15:0] ext_tcode;
		logic        stray;
	} rx_hdr_t;

	// Packet end report from the receiver
	typedef struct packed {
		logic       crc_ok;
		logic       type_err;
		logic       busy;
		logic [1:0] retry_phase;
		logic       need_resp;
	} rx_end_t;

endpackage

/* src/rx_payload_store.sv */
`timescale 1ns/1ps
module rx_payload_store #(
	parameter int WORDS = 512,
	parameter int AW    = 9
) (
	// Clock
	input  wire logic          clk_sys,
	// Write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [31:0]   wr_data,
	// Read side
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [31:0]   rd_data_r
);

	logic [31:0] mem [0:WORDS-1];

	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en)
		begin
			rd_data_r <= mem[rd_addr];
		end
	end

endmodule

/* src/rx_ack_select.sv */
`timescale 1ns/1ps
`include "rx_fmt_consts.svh"
module rx_ack_select (
	// Packet facts
	input  wire logic                 is_block,
	input  wire logic                 is_resp,
	input  wire logic                 len_match,
	input  wire rx_fmt_pkg::rx_end_t  end_info,
	// Chosen code
	output logic      [3:0]           ack_code
);

	wire data_err = is_block && (!end_info.crc_ok || !len_match);
	wire [3:0] busy_code = (end_info.retry_phase == `PHASE_A) ? `ACK_BUSY_A :
		(end_info.retry_phase == `PHASE_B) ? `ACK_BUSY_B : `ACK_BUSY_X;
	wire [3:0] ok_code = (!is_resp && end_info.need_resp) ? `ACK_PENDING : `ACK_COMPLETE;

	// Same choice whether or not an acknowledge is really sent
	assign ack_code = data_err ? `ACK_DATA_ERR :
		end_info.type_err ? `ACK_TYPE_ERR :
		end_info.busy ? busy_code : ok_code;

endmodule

/* src/async_receive_packet_format.sv */
// Overview of operation
// - Destination ID is bus number plus node
// - Transaction label stored unchanged
// - Retry code stored with standard two-bit encoding
// - Four-bit priority field stored as received
// - Source ID holds sender node ID
// - Offset high and low address local quadlet
// - Zero data length writes no data quadlets
// - First data byte in top byte
// - Last partial quadlet padded with zero bytes
// - Unsolicited responses set stray reply flag
// - Extended transaction code names lock operation
// - Status holds acknowledge code returned
// - Unacknowledged packets store would-be acknowledge code
// - Code 0001 accepted and completed
// - Code 0010 pending, never for responses
// - Busy codes X, A, B refuse packet
// - Data error only for bad payloads
// - Type error for bad header fields
// - First quadlet carries destination and header fields
// - Final quadlet carries reception status
`timescale 1ns/1ps
`include "rx_fmt_consts.svh"
module async_receive_packet_format #(
	parameter int WORDS = 512,
	parameter int AW    = 9
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	// Receiver side
	input  wire logic                rx_hdr_valid,
	input  wire rx_fmt_pkg::rx_hdr_t rx_hdr,
	input  wire logic                rx_byte_valid,
	input  wire logic [7:0]          rx_byte,
	input  wire logic                rx_end,
	input  wire rx_fmt_pkg::rx_end_t rx_end_info,
	output logic                     rx_ready,
	// Receive FIFO side
	input  wire logic                fifo_ready,
	output logic                     fifo_wr,
	output logic      [31:0]         fifo_data,
	output logic                     fifo_first,
	output logic                     fifo_last
);

	typedef enum {ST_IDLE, ST_COLLECT, ST_HDR, ST_DATA_RD, ST_DATA_WR, ST_STAT, ST_DONE} state_t;

	localparam logic [14:0] CAP_Q = 15'(WORDS);
	localparam logic [13:0] CAP_W = 14'(WORDS);

	state_t              state_r, state_nxt;
	rx_fmt_pkg::rx_hdr_t hdr_r;
	logic [15:0]         byte_cnt_r;
	logic [31:0]         word_r;
	logic [3:0]          ack_r;
	logic [2:0]          hq_r, hq_nxt;
	logic [AW:0]         dq_r, dq_nxt;
	logic                rx_ready_r, rx_ready_nxt;
	logic                fifo_wr_r, fifo_wr_nxt;
	logic [31:0]         fifo_data_r, fifo_data_nxt;
	logic                fifo_first_r, fifo_first_nxt;
	logic                fifo_last_r, fifo_last_nxt;
	logic                rd_en;
	logic [31:0]         mem_rdata;
	logic [3:0]          ack_code;

	// Packet format decode
	wire is_resp = (hdr_r.tcode == `TC_WR_RESP) || (hdr_r.tcode == `TC_RD_QRESP) ||
		(hdr_r.tcode == `TC_RD_BRESP) || (hdr_r.tcode == `TC_LOCK_RESP);
	wire is_block = (hdr_r.tcode == `TC_WR_BLK) || (hdr_r.tcode == `TC_RD_BRESP) ||
		(hdr_r.tcode == `TC_LOCK_REQ) || (hdr_r.tcode == `TC_LOCK_RESP);
	wire is_quad = (hdr_r.tcode == `TC_WR_QUAD) || (hdr_r.tcode == `TC_RD_QRESP) ||
		(hdr_r.tcode == `TC_RD_BLK);
	wire [2:0] hdr_quads = (is_block || is_quad) ? `HDR_Q_FULL : `HDR_Q_NODATA;

	// Byte packing, first byte in the top lane
	wire [1:0]  lane      = byte_cnt_r[1:0];
	wire [4:0]  shift     = {~lane, 3'b000};
	wire [31:0] byte_word = {24'h000000, rx_byte} << shift;
	wire [31:0] word_asm  = ((lane == 2'h0) ? 32'h00000000 : word_r) | byte_word;
	wire        hdr_take  = (state_r == ST_IDLE) && rx_hdr_valid && rx_ready_r;
	wire        byte_take = (state_r == ST_COLLECT) && rx_byte_valid;
	wire        end_take  = (state_r == ST_COLLECT) && rx_end;
	wire        in_cap    = byte_cnt_r[15:2] < CAP_W;
	wire        wr_full   = byte_take && (lane == 2'h3) && in_cap;
	wire        wr_part   = end_take && (lane != 2'h0) && in_cap;
	wire        mem_we    = wr_full || wr_part;
	wire [31:0] mem_wdata = wr_full ? word_asm : word_r;

	// Stored data quadlets, capped at buffer size
	wire [16:0] cnt_up     = {1'b0, byte_cnt_r} + 17'h00003;
	wire [14:0] quads_raw  = cnt_up[16:2];
	wire        trunc      = quads_raw > CAP_Q;
	wire [AW:0] stored_q   = trunc ? (AW+1)'(WORDS) : quads_raw[AW:0];
	wire        has_data   = is_block && (stored_q != '0);
	wire        len_match  = byte_cnt_r == hdr_r.data_length;
	wire        can_load   = !fifo_wr_r || fifo_ready;
	wire [31:0] pad_mask   = (lane == 2'h1) ? 32'h00ffffff : (lane == 2'h2) ? 32'h0000ffff :
		(lane == 2'h3) ? 32'h000000ff : 32'h00000000;

	// Header quadlets
	wire [31:0] hq0 = {hdr_r.dest_id, hdr_r.tlabel, hdr_r.rt, hdr_r.tcode, hdr_r.pri};
	wire [31:0] hq1 = is_resp ? {hdr_r.src_id, hdr_r.rcode, `RESP_PAD} : {hdr_r.src_id, hdr_r.off_hi};
	wire [31:0] hq2 = is_resp ? `RESP_Q2 : hdr_r.off_lo;
	wire [31:0] hq3 = is_block ? {hdr_r.data_length, hdr_r.ext_tcode} :
		(hdr_r.tcode == `TC_RD_BLK) ? {hdr_r.data_length, `LEN_PAD} : hdr_r.quad_data;
	wire [31:0] hdr_word = (hq_r == 3'h0) ? hq0 : (hq_r == 3'h1) ? hq1 : (hq_r == 3'h2) ? hq2 : hq3;
	wire [31:0] stat_word = {`STAT_PAD_HI, hdr_r.stray && is_resp, `STAT_PAD_LO, ack_r};

	rx_ack_select u_ack (
		.is_block (is_block),
		.is_resp  (is_resp),
		.len_match(len_match),
		.end_info (rx_end_info),
		.ack_code (ack_code)
	);

	rx_payload_store #(.WORDS(WORDS), .AW(AW)) u_store (
		.clk_sys  (clk_sys),
		.wr_en    (mem_we),
		.wr_addr  (byte_cnt_r[AW+1:2]),
		.wr_data  (mem_wdata),
		.rd_en    (rd_en),
		.rd_addr  (dq_r[AW-1:0]),
		.rd_data_r(mem_rdata)
	);

	always_comb
	begin
		state_nxt      = state_r;
		hq_nxt         = hq_r;
		dq_nxt         = dq_r;
		rd_en          = 1'b0;
		fifo_wr_nxt    = !can_load;
		fifo_data_nxt  = fifo_data_r;
		fifo_first_nxt = fifo_first_r;
		fifo_last_nxt  = fifo_last_r;
		case (state_r)
			ST_IDLE:
			begin
				if (hdr_take)
				begin
					state_nxt = ST_COLLECT;
				end
			end
			ST_COLLECT:
			begin
				if (rx_end)
				begin
					state_nxt = ST_HDR;
					hq_nxt    = 3'h0;
				end
			end
			ST_HDR:
			begin
				if (can_load)
				begin
					fifo_wr_nxt    = 1'b1;
					fifo_data_nxt  = hdr_word;
					fifo_first_nxt = hq_r == 3'h0;
					fifo_last_nxt  = 1'b0;
					hq_nxt         = hq_r + 3'h1;
					dq_nxt         = '0;
					if (hq_r == hdr_quads - 3'h1)
					begin
						state_nxt = has_data ? ST_DATA_RD : ST_STAT;
					end
				end
			end
			ST_DATA_RD:
			begin
				rd_en     = 1'b1;
				state_nxt = ST_DATA_WR;
			end
			ST_DATA_WR:
			begin
				if (can_load)
				begin
					fifo_wr_nxt    = 1'b1;
					fifo_data_nxt  = mem_rdata;
					fifo_first_nxt = 1'b0;
					dq_nxt         = dq_r + 1'b1;
					state_nxt      = (dq_r == stored_q - 1'b1) ? ST_STAT : ST_DATA_RD;
				end
			end
			ST_STAT:
			begin
				if (can_load)
				begin
					fifo_wr_nxt    = 1'b1;
					fifo_data_nxt  = stat_word;
					fifo_first_nxt = 1'b0;
					fifo_last_nxt  = 1'b1;
					state_nxt      = ST_DONE;
				end
			end
			ST_DONE:
			begin
				if (can_load)
				begin
					fifo_last_nxt = 1'b0;
					state_nxt     = ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// New packet only once the previous one is fully written
	assign rx_ready_nxt = state_nxt == ST_IDLE;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r      <= ST_IDLE;
			hq_r         <= 3'h0;
			dq_r         <= '0;
			rx_ready_r   <= 1'b0;
			fifo_wr_r    <= 1'b0;
			fifo_data_r  <= 32'h00000000;
			fifo_first_r <= 1'b0;
			fifo_last_r  <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			hq_r         <= hq_nxt;
			dq_r         <= dq_nxt;
			rx_ready_r   <= rx_ready_nxt;
			fifo_wr_r    <= fifo_wr_nxt;
			fifo_data_r  <= fifo_data_nxt;
			fifo_first_r <= fifo_first_nxt;
			fifo_last_r  <= fifo_last_nxt;
		end
	end

	// Packet capture
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hdr_r      <= '0;
			byte_cnt_r <= 16'h0000;
			word_r     <= 32'h00000000;
			ack_r      <= 4'h0;
		end
		else
		begin
			if (hdr_take)
			begin
				hdr_r      <= rx_hdr;
				byte_cnt_r <= 16'h0000;
				word_r     <= 32'h00000000;
			end
			if (byte_take)
			begin
				word_r     <= word_asm;
				byte_cnt_r <= byte_cnt_r + 16'h0001;
			end
			if (end_take)
			begin
				ack_r <= ack_code;
			end
		end
	end

	assign rx_ready   = rx_ready_r;
	assign fifo_wr    = fifo_wr_r;
	assign fifo_data  = fifo_data_r;
	assign fifo_first = fifo_first_r;
	assign fifo_last  = fifo_last_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_first_quad_dest;
		fifo_wr_r && fifo_first_r |-> fifo_data_r[31:16] == hdr_r.dest_id && fifo_data_r[15:10] == hdr_r.tlabel;
	endproperty
	a_first_quad_dest: assert property (p_first_quad_dest) else $error("first quadlet header mismatch");

	property p_retry_prio;
		fifo_wr_r && fifo_first_r |-> fifo_data_r[9:8] == hdr_r.rt && fifo_data_r[3:0] == hdr_r.pri;
	endproperty
	a_retry_prio: assert property (p_retry_prio) else $error("retry or priority not stored");

	property p_status_ack;
		fifo_wr_r && fifo_last_r |-> fifo_data_r[3:0] == ack_r && state_r == ST_DONE;
	endproperty
	a_status_ack: assert property (p_status_ack) else $error("status quadlet lacks ack code");

	property p_resp_not_pending;
		fifo_wr_r && fifo_last_r && is_resp |-> fifo_data_r[3:0] != `ACK_PENDING;
	endproperty
	a_resp_not_pending: assert property (p_resp_not_pending) else $error("pending ack on response");

	property p_data_err_block;
		end_take && ack_code == `ACK_DATA_ERR |-> is_block;
	endproperty
	a_data_err_block: assert property (p_data_err_block) else $error("data error on packet without payload");

	property p_zero_len;
		state_r == ST_DATA_RD |-> stored_q != '0 && is_block;
	endproperty
	a_zero_len: assert property (p_zero_len) else $error("data quadlet for empty payload");

	property p_first_byte_top;
		byte_take && lane == 2'h0 |=> word_r[31:24] == $past(rx_byte);
	endproperty
	a_first_byte_top: assert property (p_first_byte_top) else $error("byte not in top lane");

	property p_pad_zero;
		state_r == ST_DATA_WR && can_load && dq_r == stored_q - 1'b1 && !trunc
			|=> (fifo_data_r & $past(pad_mask)) == 32'h00000000;
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("padding bytes not zero");

	property p_hold_stall;
		fifo_wr_r && !fifo_ready |=> fifo_wr_r && $stable(fifo_data_r) && $stable(fifo_last_r);
	endproperty
	a_hold_stall: assert property (p_hold_stall) else $error("quadlet dropped under stall");

	property p_busy_not_ready;
		state_r != ST_IDLE |-> !rx_ready_r;
	endproperty
	a_busy_not_ready: assert property (p_busy_not_ready) else $error("ready raised mid packet");

	property p_stray_flag;
		fifo_wr_r && fifo_last_r |-> fifo_data_r[16] == (hdr_r.stray && is_resp);
	endproperty
	a_stray_flag: assert property (p_stray_flag) else $error("stray reply flag wrong");

	c_block_data: cover property (state_r == ST_DATA_WR && can_load && dq_r == stored_q - 1'b1);
	c_zero_len: cover property (end_take && is_block && byte_cnt_r == 16'h0000);
	c_busy_ack: cover property (fifo_wr_r && fifo_last_r && fifo_data_r[3:0] == `ACK_BUSY_A);
	c_stall: cover property (fifo_wr_r && !fifo_ready ##1 fifo_wr_r && fifo_ready);

endmodule

/* sim/rx_link_model.sv */
`timescale 1ns/1ps
module rx_link_model (
	// Clock
	input  wire logic          clk_sys,
	// Toward the block
	input  wire logic          rx_ready,
	output logic               rx_hdr_valid,
	output rx_fmt_pkg::rx_hdr_t rx_hdr,
	output logic               rx_byte_valid,
	output logic [7:0]         rx_byte,
	output logic               rx_end,
	output rx_fmt_pkg::rx_end_t rx_end_info
);
	initial
	begin
		rx_hdr_valid = 1'b0;
		rx_hdr = '0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_end = 1'b0;
		rx_end_info = '0;
	end

	// Header, payload bytes a0 upward, then end mark; released lines inverted
	// Ok low when the block never became ready
	task automatic send(input rx_fmt_pkg::rx_hdr_t h, input int nb, input rx_fmt_pkg::rx_end_t e,
		output bit ok);
		int i;
		i = 0;
		while (!rx_ready && i < 500)
		begin
			@(negedge clk_sys);
			i++;
		end
		ok = rx_ready;
		@(posedge clk_sys);
		rx_hdr_valid <= 1'b1;
		rx_hdr <= h;
		for (i = 0; i < nb; i++)
		begin
			@(posedge clk_sys);
			rx_hdr_valid <= 1'b0;
			rx_hdr <= rx_fmt_pkg::rx_hdr_t'(~h);
			rx_byte_valid <= 1'b1;
			rx_byte <= 8'ha0 + 8'(i);
		end
		@(posedge clk_sys);
		rx_hdr_valid <= 1'b0;
		rx_hdr <= rx_fmt_pkg::rx_hdr_t'(~h);
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		rx_end <= 1'b1;
		rx_end_info <= e;
		@(posedge clk_sys);
		rx_end <= 1'b0;
		rx_end_info <= rx_fmt_pkg::rx_end_t'(~e);
	endtask
endmodule

/* sim/async_receive_packet_format_test.sv */
`timescale 1ns/1ps
module async_receive_packet_format_test;
	logic                clk_sys;
	logic                reset_n;
	logic                fifo_ready;
	logic                stall;
	logic                rx_hdr_valid;
	logic                rx_byte_valid;
	logic                rx_end;
	logic                rx_ready;
	logic                fifo_wr;
	logic                fifo_first;
	logic                fifo_last;
	logic [7:0]          rx_byte;
	logic [31:0]         fifo_data;
	rx_fmt_pkg::rx_hdr_t rx_hdr;
	rx_fmt_pkg::rx_end_t rx_end_info;
	logic [33:0]         got[$];
	logic [33:0]         exp[$];
	int                  n_fail;
	int                  checks;

	async_receive_packet_format #(.WORDS(8), .AW(3)) async_receive_packet_format_i (
		.clk_sys(clk_sys), .reset_n(reset_n), .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_end(rx_end), .rx_end_info(rx_end_info),
		.rx_ready(rx_ready), .fifo_ready(fifo_ready), .fifo_wr(fifo_wr), .fifo_data(fifo_data),
		.fifo_first(fifo_first), .fifo_last(fifo_last));

	rx_link_model rx_link_model_i (
		.clk_sys(clk_sys), .rx_ready(rx_ready), .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_end(rx_end), .rx_end_info(rx_end_info));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// FIFO sink, stalling every other cycle when asked
	always @(posedge clk_sys)
	begin
		fifo_ready <= stall ? ~fifo_ready : 1'b1;
		if (fifo_wr && fifo_ready)
			got.push_back({fifo_last, fifo_first, fifo_data});
	end

	task automatic chk(input logic [33:0] seen, input logic [33:0] want);
		checks++;
		if (seen !== want)
		begin
			n_fail++;
			$display("FAIL %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic rx_fmt_pkg::rx_hdr_t hdr(input logic [3:0] tc);
		rx_fmt_pkg::rx_hdr_t h;
		h = '{16'hffc2, 6'h2d, rx_fmt_pkg::RT_RETRY_X, tc, 4'h0, 16'hffc5, 16'h1234, 32'h89abcdec,
			4'h0, 32'h5a5a0f0f, 16'h0000, 16'h0000, 1'b0};
		return h;
	endfunction

	// Send one packet and compare the whole quadlet stream with what it must give
	task automatic pkt(input rx_fmt_pkg::rx_hdr_t h, input int nb, input rx_fmt_pkg::rx_end_t e,
		input logic [3:0] ack);
		logic        resp;
		logic        blk;
		int          i;
		logic [31:0] w;
		bit          ok;
		resp = h.tcode inside {4'h2, 4'h6, 4'h7, 4'hb};
		blk = h.tcode inside {4'h1, 4'h7, 4'h9, 4'hb};
		exp.delete();
		got.delete();
		exp.push_back({2'b01, h.dest_id, h.tlabel, h.rt, h.tcode, h.pri});
		exp.push_back({2'b00, h.src_id, resp ? {h.rcode, 12'h000} : h.off_hi});
		exp.push_back({2'b00, resp ? 32'h00000000 : h.off_lo});
		if (!(h.tcode inside {4'h2, 4'h4}))
			exp.push_back({2'b00, blk ? {h.data_length, h.ext_tcode} :
				(h.tcode == 4'h5 ? {h.data_length, 16'h0000} : h.quad_data)});
		w = 32'h00000000;
		if (blk)
			for (i = 0; i < nb; i++)
			begin
				w[31 - 8 * (i % 4) -: 8] = 8'ha0 + 8'(i);
				if (i % 4 == 3 || i == nb - 1)
				begin
					exp.push_back({2'b00, w});
					w = 32'h00000000;
				end
			end
		exp.push_back({2'b10, 15'h0000, h.stray && resp, 12'h000, ack});
		rx_link_model_i.send(h, nb, e, ok);
		i = 0;
		while ((got.size() < exp.size() || !rx_ready) && i < 400)
		begin
			@(negedge clk_sys);
			i++;
		end
		if (i == 400 || !ok)
		begin
			n_fail++;
			print_verdict();
		end
		chk(34'(got.size()), 34'(exp.size()));
		for (i = 0; i < exp.size() && i < got.size(); i++)
			chk(got[i], exp[i]);
	endtask

	task automatic t_quad();
		rx_fmt_pkg::rx_hdr_t h;
		int r;
		for (r = 0; r < 4; r++)
		begin
			h = hdr(4'h0);
			h.rt = rx_fmt_pkg::rt_t'(2'(r));
			h.pri = 4'(r * 3);
			pkt(h, 0, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 4'h1);
		end
		pkt(hdr(4'h4), 0, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b1}, 4'h2);
	endtask

	task automatic t_block();
		rx_fmt_pkg::rx_hdr_t h;
		h = hdr(4'h1);
		h.data_length = 16'h0006;
		stall = 1'b1;
		pkt(h, 6, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b1}, 4'h2);
		stall = 1'b0;
		h.data_length = 16'h0000;
		pkt(h, 0, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 4'h1);
		h = hdr(4'h5);
		h.data_length = 16'h0010;
		pkt(h, 0, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b1}, 4'h2);
	endtask

	task automatic t_lock();
		rx_fmt_pkg::rx_hdr_t h;
		int p;
		h = hdr(4'h9);
		h.dest_id = 16'hffff;
		h.ext_tcode = 16'h0002;
		h.data_length = 16'h0008;
		for (p = 0; p < 3; p++)
			pkt(h, 8, '{1'b1, 1'b0, 1'b1, 2'(p), 1'b1}, 4'h4 + 4'(p));
	endtask

	task automatic t_resp();
		rx_fmt_pkg::rx_hdr_t h;
		h = hdr(4'h2);
		h.stray = 1'b1;
		h.rcode = 4'h7;
		pkt(h, 0, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b1}, 4'h1);
		h = hdr(4'h6);
		pkt(h, 0, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 4'h1);
		h = hdr(4'hb);
		h.stray = 1'b1;
		h.data_length = 16'h0004;
		pkt(h, 4, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 4'h1);
	endtask

	task automatic t_err();
		rx_fmt_pkg::rx_hdr_t h;
		h = hdr(4'h1);
		h.data_length = 16'h0006;
		pkt(h, 6, '{1'b0, 1'b0, 1'b0, 2'h0, 1'b0}, 4'hd);
		pkt(h, 5, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 4'hd);
		pkt(hdr(4'h4), 0, '{1'b1, 1'b1, 1'b1, 2'h1, 1'b1}, 4'he);
		pkt(hdr(4'h4), 0, '{1'b0, 1'b0, 1'b0, 2'h0, 1'b0}, 4'h1);
	endtask

	// Mid-run reset: outputs clear, ready one edge after release, next packet clean
	task automatic t_reset();
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(negedge clk_sys);
		chk(34'({rx_ready, fifo_wr, fifo_first, fifo_last}), 34'h0);
		chk(34'(fifo_data), 34'h0);
		@(negedge clk_sys);
		chk(34'(rx_ready), 34'h1);
		pkt(hdr(4'h0), 0, '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0}, 4'h1);
	endtask

	initial
	begin
		reset_n = 1'b0;
		stall = 1'b0;
		n_fail = 0;
		checks = 0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_quad();
		t_block();
		t_lock();
		t_resp();
		t_err();
		t_reset();
		print_verdict();
	end
endmodule
